// *** design/dac_input_timing.sv ***
// input timing core: quarter-rate clock, delay-locked loop, word ordering, avalon registers
//
// Our own choices: the register addresses and register access over Avalon-MM.
`include "dac_timing_consts.svh"

module dac_input_timing (
  input  wire logic                 core_clk,                // full sample-rate clock
  input  wire logic                 rst,                     // sync reset, high
  input  wire logic [`ADDR_W-1:0]   address,                 // avalon byte address
  input  wire logic                 read,                    // avalon read
  input  wire logic                 write,                   // avalon write
  input  wire logic [31:0]          writedata,               // avalon write data
  input  wire logic [3:0]           byteenable,              // avalon byte enables
  output logic [31:0]               readdata,                // avalon read data
  output logic                      waitrequest,             // avalon wait
  input  wire logic                 reference_bit_clock_in,  // returned reference clock
  input  wire logic [`WORD_W-1:0]   port_a_word,             // port a data
  input  wire logic [`WORD_W-1:0]   port_b_word,             // port b data
  output logic                      source_timing_clock_out, // quarter-rate clock to source
  output logic                      latchClock,              // internal quarter-rate latch clock
  output logic signed [`TAP_W-1:0]  delayTaps,               // delay line setting
  output logic                      loopLocked,              // loop at quadrature
  output logic [`WORD_W-1:0]        sampleOut                // full-rate sample word
);

  localparam logic signed [`TAP_W-1:0] NegLimit = `TAP_W'(-(`NEG_TAPS));
  localparam logic signed [`TAP_W-1:0] PosLimit = `TAP_W'(`POS_TAPS);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic              holdReg;
  logic              invertReg;
  logic [3:0]        modeReg;
  logic [`FREQ_W-1:0] freqReg;
  logic              ackReg;

  wire logic         access;
  wire logic         writeTaken;
  wire logic         hitCtrl;
  wire logic         hitStatus;
  wire logic         hitFreq;
  wire logic [31:0]  ctrlView;
  wire logic [31:0]  statusView;
  wire logic [31:0]  freqView;
  wire logic [31:0]  readMux;

  // one wait cycle: the answer comes in the cycle after the request is seen
  assign access     = (read | write) & ~ackReg;
  assign writeTaken = write & ackReg;
  assign hitCtrl    = (address == `CTRL_OFFSET);
  assign hitStatus  = (address == `STATUS_OFFSET);
  assign hitFreq    = (address == `FREQ_OFFSET);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ackReg      <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      ackReg      <= access;
      waitrequest <= ~access;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdReg   <= `CTRL_HOLD_RESET;
      invertReg <= `CTRL_INVERT_RESET;
      modeReg   <= `CTRL_MODE_RESET;
    end else if (writeTaken && hitCtrl && byteenable[0]) begin
      holdReg   <= writedata[`CTRL_HOLD_BIT];
      invertReg <= writedata[`CTRL_INVERT_BIT];
      modeReg   <= writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freqReg <= `FREQ_RESET;
    end else if (writeTaken && hitFreq) begin
      if (byteenable[0]) begin
        freqReg[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        freqReg[`FREQ_W-1:8] <= writedata[`FREQ_W-1:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-rate clock

  logic [1:0] phaseCnt;
  wire  logic [1:0] phaseNext;

  assign phaseNext = phaseCnt + 2'h1;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phaseCnt                <= 2'h0;
      source_timing_clock_out <= 1'b0;
      latchClock              <= 1'b0;
    end else begin
      phaseCnt                <= phaseNext;
      source_timing_clock_out <= phaseNext[1];
      latchClock              <= phaseNext[1] ^ invertReg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay-locked loop

  logic                      refPrev;
  logic                      lastWasAdd;
  logic                      seenDecision;
  dac_timing_pkg::loop_state_e loopState;
  dac_timing_pkg::loop_state_e loopNext;
  dac_timing_pkg::quadrant_t   quadrant;

  wire logic                 refEdge;
  wire logic                 addPulse;
  wire logic                 subPulse;
  wire logic                 freqInRange;
  wire logic                 loopRun;
  wire logic                 decided;
  wire logic                 reversed;
  wire logic                 canAdd;
  wire logic                 canSub;

  // inputs are synchronous to the sample clock, so no synchroniser here;
  // the reference clock may stand still while held, which only freezes the detector
  assign refEdge     = reference_bit_clock_in & ~refPrev;
  assign freqInRange = (freqReg >= `FREQ_MIN_MHZ) && (freqReg <= `FREQ_MAX_MHZ);
  assign loopRun     = ~holdReg & freqInRange;
  assign decided     = addPulse | subPulse;
  assign reversed    = decided & seenDecision & (addPulse != lastWasAdd);
  assign canAdd      = delayTaps < PosLimit;
  assign canSub      = delayTaps > NegLimit;

  quadrant_detector detector (
    .core_clk (core_clk),
    .rst      (rst),
    .refEdge  (refEdge),
    .phaseCnt (phaseCnt),
    .taps     (delayTaps),
    .invert   (invertReg),
    .addPulse (addPulse),
    .subPulse (subPulse),
    .quadrant (quadrant)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      refPrev <= 1'b0;
    end else begin
      refPrev <= reference_bit_clock_in;
    end
  end

  // a reversal of direction means the edge sits on the stable boundary
  always_comb begin
    loopNext = loopState;
    case (loopState)
      dac_timing_pkg::LOOP_HOLD: begin
        if (loopRun) begin
          loopNext = dac_timing_pkg::LOOP_TRACK;
        end
      end
      dac_timing_pkg::LOOP_TRACK: begin
        if (!loopRun) begin
          loopNext = dac_timing_pkg::LOOP_HOLD;
        end else if (reversed) begin
          loopNext = dac_timing_pkg::LOOP_LOCKED;
        end
      end
      dac_timing_pkg::LOOP_LOCKED: begin
        if (!loopRun) begin
          loopNext = dac_timing_pkg::LOOP_HOLD;
        end else if (decided && seenDecision && !reversed) begin
          loopNext = dac_timing_pkg::LOOP_TRACK;
        end
      end
      default: begin
        loopNext = dac_timing_pkg::LOOP_HOLD;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      loopState    <= dac_timing_pkg::LOOP_HOLD;
      loopLocked   <= 1'b0;
      seenDecision <= 1'b0;
      lastWasAdd   <= 1'b0;
    end else begin
      loopState    <= loopNext;
      loopLocked   <= (loopNext == dac_timing_pkg::LOOP_LOCKED);
      if (loopNext == dac_timing_pkg::LOOP_HOLD) begin
        seenDecision <= 1'b0;
      end else if (decided) begin
        seenDecision <= 1'b1;
        lastWasAdd   <= addPulse;
      end
    end
  end

  // saturating delay line; held at the restart position while the loop is held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      delayTaps <= `TAP_W'sh0;
    end else if (!loopRun || loopState == dac_timing_pkg::LOOP_HOLD) begin
      delayTaps <= `TAP_W'sh0;
    end else if (addPulse && canAdd) begin
      delayTaps <= delayTaps + `TAP_W'sh1;
    end else if (subPulse && canSub) begin
      delayTaps <= delayTaps - `TAP_W'sh1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word ordering

  dac_timing_pkg::input_mode_e modeSel;
  wire logic modeValid;
  wire logic captureSlot;

  // the mode field must be one-hot; anything else falls back to dual-port order
  assign modeValid   = (modeReg == 4'h1) || (modeReg == 4'h2) ||
                       (modeReg == 4'h4) || (modeReg == 4'h8);
  assign captureSlot = ~phaseCnt[0];

  always_comb begin
    modeSel = dac_timing_pkg::MODE_DUAL;
    if (modeValid) begin
      modeSel = dac_timing_pkg::input_mode_e'(modeReg);
    end
  end

  word_sequencer sequencer (
    .core_clk  (core_clk),
    .rst       (rst),
    .capture   (captureSlot),
    .mode      (modeSel),
    .portA     (port_a_word),
    .portB     (port_b_word),
    .sampleOut (sampleOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  assign ctrlView   = {26'h0, modeReg, invertReg, holdReg};
  assign statusView = {21'h0, freqInRange, loopState, quadrant, delayTaps};
  assign freqView   = {20'h0, freqReg};
  assign readMux    = hitCtrl   ? ctrlView :
                      hitStatus ? statusView :
                      hitFreq   ? freqView : 32'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (access && read) begin
      readdata <= readMux;
    end
  end

endmodule

// *** inc/dac_timing_consts.svh ***
// offsets, field positions, reset values and timing counts of the input timing block
//
// Summary of operation
// - core runs full rate, ports half rate
// - source clock out is sample clock over four
// - returned reference clock feeds loop phase detector
// - lock at quadrature with quarter-rate latch clock
// - four quadrants each choose add or subtract
// - normal lock point at quarter period boundary
// - inversion: three-quarter point, swapped zones, inverted clock
// - delay line reaches minus 150, plus 600 ps
// - loop only specified from 1 to 2.4 GHz
// - hold pin keeps loop at restart position
// - four exclusive modes set output word order
// - words are straight binary, bit 13 msb
`ifndef DAC_TIMING_CONSTS_SVH
`define DAC_TIMING_CONSTS_SVH

`define WORD_W            14
`define ADDR_W            4
`define TAP_W             5

// register byte offsets
`define CTRL_OFFSET       4'h0
`define STATUS_OFFSET     4'h4
`define FREQ_OFFSET       4'h8

// control register fields
`define CTRL_HOLD_BIT     0
`define CTRL_INVERT_BIT   1
`define CTRL_MODE_LSB     2
`define CTRL_MODE_MSB     5
`define CTRL_HOLD_RESET   1'b1
`define CTRL_INVERT_RESET 1'b0
`define CTRL_MODE_RESET   4'h1

// status register fields
`define STAT_TAPS_LSB     0
`define STAT_TAPS_MSB     4
`define STAT_QUAD_LSB     5
`define STAT_QUAD_MSB     6
`define STAT_STATE_LSB    7
`define STAT_STATE_MSB    9
`define STAT_RANGE_BIT    10

// sample clock frequency register, in MHz
`define FREQ_W            12
`define FREQ_RESET        12'h960
`define FREQ_MIN_MHZ      12'h3e8
`define FREQ_MAX_MHZ      12'h960

// delay line: four taps per quadrant, so a tap is a fraction of a sample period
`define TAP_PS            100
`define MIN_SUB_DELAY_PS  150
`define MIN_ADD_DELAY_PS  600
`define NEG_TAPS          ((`MIN_SUB_DELAY_PS + `TAP_PS - 1) / `TAP_PS)
`define POS_TAPS          ((`MIN_ADD_DELAY_PS + `TAP_PS - 1) / `TAP_PS)

`endif

// *** inc/dac_timing_pkg.sv ***
// types and shared decoding of the input timing block
package dac_timing_pkg;

  typedef enum logic [2:0] {
    LOOP_HOLD   = 3'b001,
    LOOP_TRACK  = 3'b010,
    LOOP_LOCKED = 3'b100
  } loop_state_e;

  typedef enum logic [3:0] {
    MODE_DUAL     = 4'b0001,
    MODE_REPEAT   = 4'b0010,
    MODE_NEGATE   = 4'b0100,
    MODE_ZERO     = 4'b1000
  } input_mode_e;

  typedef logic [1:0] quadrant_t;

  // add-delay zones: Q1 and Q4 normally, Q2 and Q3 when the lock point is inverted
  function automatic logic wantsAdd(input quadrant_t q, input logic invert);
    logic addZone;
    addZone = (q == 2'h0) || (q == 2'h3);
    return addZone ^ invert;
  endfunction

endpackage

// *** design/quadrant_detector.sv ***
// quadrature phase detector: places each reference rising edge in one of four quadrants
`include "dac_timing_consts.svh"

module quadrant_detector (
  input  wire logic                           core_clk,  // sample-rate clock
  input  wire logic                           rst,       // sync reset, high
  input  wire logic                           refEdge,   // reference rising edge seen
  input  wire logic [1:0]                     phaseCnt,  // quarter-rate clock phase
  input  wire logic signed [`TAP_W-1:0]       taps,      // current delay setting
  input  wire logic                           invert,    // lock point inversion
  output logic                                addPulse,  // one-cycle add request
  output logic                                subPulse,  // one-cycle subtract request
  output dac_timing_pkg::quadrant_t           quadrant   // last measured quadrant
);

  // four taps per quadrant: position in taps wraps once per quarter-rate period
  wire logic [3:0]                position;
  wire dac_timing_pkg::quadrant_t quadNow;
  wire logic                      addNow;

  assign position = {phaseCnt, 2'b00} + taps[3:0];
  assign quadNow  = position[3:2];
  assign addNow   = dac_timing_pkg::wantsAdd(quadNow, invert);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addPulse <= 1'b0;
      subPulse <= 1'b0;
      quadrant <= 2'h0;
    end else begin
      addPulse <= refEdge & addNow;
      subPulse <= refEdge & ~addNow;
      if (refEdge) begin
        quadrant <= quadNow;
      end
    end
  end

endmodule

// *** design/word_sequencer.sv ***
// orders the two port words into the full-rate sample stream
`include "dac_timing_consts.svh"

module word_sequencer (
  input  wire logic                     core_clk,   // sample-rate clock
  input  wire logic                     rst,        // sync reset, high
  input  wire logic                     capture,    // latch strobe, every second cycle
  input  wire dac_timing_pkg::input_mode_e mode,    // validated one-hot mode
  input  wire logic [`WORD_W-1:0]       portA,      // port a word
  input  wire logic [`WORD_W-1:0]       portB,      // port b word
  output logic [`WORD_W-1:0]            sampleOut   // full-rate output word
);

  logic [`WORD_W-1:0] secondReg;
  wire  logic [`WORD_W-1:0] secondNext;

  // straight binary: negation about mid-scale is the bitwise complement
  assign secondNext = (mode == dac_timing_pkg::MODE_DUAL)   ? portB :
                      (mode == dac_timing_pkg::MODE_REPEAT) ? portA :
                      (mode == dac_timing_pkg::MODE_NEGATE) ? ~portA :
                      {`WORD_W{1'b0}};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sampleOut <= {`WORD_W{1'b0}};
      secondReg <= {`WORD_W{1'b0}};
    end else if (capture) begin
      sampleOut <= portA;
      secondReg <= secondNext;
    end else begin
      sampleOut <= secondReg;
    end
  end

endmodule

// *** tb/dac_input_timing_asserts.sv ***
// port-level checker for the input timing core, bound to its top module
`include "dac_timing_consts.svh"

module dac_input_timing_asserts (
  input wire logic                core_clk,                // sample clock
  input wire logic                rst,                     // sync reset, high
  input wire logic [`ADDR_W-1:0]  address,                 // avalon byte address
  input wire logic                read,                    // avalon read
  input wire logic                write,                   // avalon write
  input wire logic                waitrequest,             // avalon wait
  input wire logic                reference_bit_clock_in,  // returned reference clock
  input wire logic [`WORD_W-1:0]  port_a_word,             // port a data
  input wire logic                source_timing_clock_out, // quarter-rate clock out
  input wire logic                latchClock,              // internal latch clock
  input wire logic signed [`TAP_W-1:0] delayTaps,          // delay setting
  input wire logic                loopLocked,              // loop at quadrature
  input wire logic [`WORD_W-1:0]  sampleOut                // full-rate word
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire ctrlCommit = write && !waitrequest && (address == `CTRL_OFFSET);

  sequence highPair;
    source_timing_clock_out ##1 source_timing_clock_out;
  endsequence
  sequence lowPair;
    !source_timing_clock_out ##1 !source_timing_clock_out;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  chk_clock_quarter_rate: assert property (
    $rose(source_timing_clock_out) |-> highPair ##1 lowPair ##1 source_timing_clock_out)
    else $error("source clock not two high two low");
  // one extra edge allowed for the invert bit to reach the latch clock
  chk_latch_phase_fixed: assert property (
    !ctrlCommit && !$past(ctrlCommit) |=> $stable(latchClock ^ source_timing_clock_out))
    else $error("latch clock phase moved without a control write");
  chk_wait_one_cycle: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  chk_wait_idle_high: assert property (
    !read && !write && waitrequest |=> waitrequest)
    else $error("waitrequest dropped without a request");
  chk_taps_in_range: assert property (
    delayTaps >= -5'sd2 && delayTaps <= 5'sd6)
    else $error("delay setting outside line range");
  chk_taps_single_step: assert property (
    $changed(delayTaps) && delayTaps != 5'sd0 |->
      delayTaps == $past(delayTaps) + 5'sd1 || delayTaps == $past(delayTaps) - 5'sd1)
    else $error("delay setting jumped more than one tap");
  // edge sampled at R, pulse registered at R, tap registered at R+1, seen here at R+2
  chk_step_after_edge: assert property (
    $changed(delayTaps) && delayTaps != 5'sd0 |->
      $past(reference_bit_clock_in, 2) && !$past(reference_bit_clock_in, 3))
    else $error("delay step without a reference edge");
  chk_word_a_capture: assert property (
    !$past(rst) && $stable(source_timing_clock_out) |-> sampleOut == $past(port_a_word))
    else $error("first word of pair is not port a");
  chk_reset_outputs: assert property (
    $fell(rst) |-> waitrequest && delayTaps == 5'sd0 && !loopLocked && sampleOut == '0)
    else $error("outputs not at reset values");
endmodule

bind dac_input_timing dac_input_timing_asserts chk (
  .core_clk, .rst, .address, .read, .write, .waitrequest, .reference_bit_clock_in,
  .port_a_word, .source_timing_clock_out, .latchClock, .delayTaps, .loopLocked, .sampleOut
);

// *** tb/ref_source_model.sv ***
// far-side data source: returns the quarter-rate clock as the reference bit clock
module ref_source_model (
  input  wire logic       core_clk,   // sample clock
  input  wire logic       rst,        // sync reset, high
  input  wire logic       clkFromDut, // quarter-rate clock from the core
  input  wire logic [1:0] lagCycles,  // board delay in sample periods, less one
  input  wire logic       running,    // low: reference stands still
  output logic            refClk      // returned reference clock
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] lineReg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lineReg <= 4'h0;
    end else begin
      lineReg <= {lineReg[2:0], clkFromDut};
    end
  end

  // stopped source parks at a valid low level rather than floating
  assign refClk = running ? lineReg[lagCycles] : 1'b0;
endmodule

// *** tb/test_dac_input_timing.sv ***
// self-checking bench for the input timing core with a reference source model
`include "dac_timing_consts.svh"

module test_dac_input_timing;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [3:0]         mode;
    logic [`WORD_W-1:0] a;
    logic [`WORD_W-1:0] b;
    logic [`WORD_W-1:0] second;
  } row_s;

  logic                       core_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [`ADDR_W-1:0]         address = '0;
  logic                       read = 1'b0;
  logic                       write = 1'b0;
  logic [31:0]                writedata = '0;
  logic [31:0]                readdata;
  logic                       waitrequest;
  logic                       reference_bit_clock_in;
  logic [`WORD_W-1:0]         port_a_word = '0;
  logic [`WORD_W-1:0]         port_b_word = '0;
  logic                       source_timing_clock_out;
  logic                       latchClock;
  logic signed [`TAP_W-1:0]   delayTaps;
  logic                       loopLocked;
  logic [`WORD_W-1:0]         sampleOut;
  logic [1:0]                 lag = 2'h0;
  logic                       running = 1'b0;
  int                         errorCnt = 0;
  int                         samplesChecked = 0;
  logic [31:0]                rd;
  logic [`WORD_W-1:0]         v0;
  logic [`WORD_W-1:0]         v1;
  int                         n;
  int                         hits;
  // invalid mode code is treated as dual
  row_s rows [6] = '{
    '{4'h1, 14'h2a5c, 14'h13c7, 14'h13c7}, '{4'h2, 14'h2a5c, 14'h13c7, 14'h2a5c},
    '{4'h4, 14'h2a5c, 14'h13c7, 14'h15a3}, '{4'h8, 14'h3fff, 14'h13c7, 14'h0000},
    '{4'h4, 14'h0000, 14'h3fff, 14'h3fff}, '{4'h0, 14'h0001, 14'h2000, 14'h2000}};

  always #5 core_clk = ~core_clk;

  dac_input_timing uut (
    .core_clk, .rst, .address, .read, .write, .writedata, .byteenable(4'hf), .readdata,
    .waitrequest, .reference_bit_clock_in, .port_a_word, .port_b_word,
    .source_timing_clock_out, .latchClock, .delayTaps, .loopLocked, .sampleOut);

  ref_source_model source (
    .core_clk, .rst, .clkFromDut(source_timing_clock_out), .lagCycles(lag), .running,
    .refClk(reference_bit_clock_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stopTest();
    $display("checked %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic checkVal(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // an edge always passes first so a request is never lowered and raised at once
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                     output logic [31:0] data);
    int k;
    @(posedge core_clk);
    address <= addr;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0) begin
      errorCnt++;
      stopTest();
    end else begin
      data = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, `CTRL_OFFSET, '0, rd);
    checkVal("ctrl", 32'h5, rd);
    bus(1'b0, `FREQ_OFFSET, '0, rd);
    checkVal("freq", 32'h960, rd);
    bus(1'b1, `STATUS_OFFSET, 32'hffffffff, rd);
    bus(1'b0, `STATUS_OFFSET, '0, rd);
    checkVal("status", 32'h480, rd & 32'h780);
    bus(1'b0, 4'hc, '0, rd);
    checkVal("unmapped", 32'h0, rd);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      n += int'(source_timing_clock_out === 1'b1);
    end
    checkVal("clkHigh", 32'd20, 32'(n));
    $display("test registers done");
    foreach (rows[i]) begin
      bus(1'b1, `CTRL_OFFSET, {26'h0, rows[i].mode, 2'b01}, rd);
      port_a_word <= rows[i].a;
      port_b_word <= rows[i].b;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      v0 = sampleOut;
      @(negedge core_clk);
      v1 = sampleOut;
      checkVal("wordA", 32'(rows[i].a), 32'((v1 === rows[i].a) ? v1 : v0));
      checkVal("word2", 32'(rows[i].second), 32'((v1 === rows[i].a) ? v0 : v1));
    end
    $display("test word order done");
    // not every board lag locks, so each setting must lock for at least one
    for (int inv = 0; inv < 2; inv++) begin
      hits = 0;
      for (int d = 0; d < 4; d++) begin
        lag <= 2'(d);
        running <= 1'b1;
        bus(1'b1, `CTRL_OFFSET, 32'h4 | (32'(inv) << 1), rd);
        // fixed observation window: some lags never lock, so this is not a wait
        repeat (400) @(posedge core_clk);
        hits += int'(loopLocked === 1'b1);
        @(negedge core_clk);
        checkVal("latch", 32'(source_timing_clock_out ^ inv[0]), 32'(latchClock));
        bus(1'b1, `CTRL_OFFSET, 32'h5 | (32'(inv) << 1), rd);
        running <= 1'b0;
        repeat (4) @(posedge core_clk);
        checkVal("holdLoop", 32'h0, 32'({delayTaps, loopLocked}));
      end
      checkVal("lockSeen", 32'h1, 32'(hits != 0));
    end
    $display("test loop done");
    running <= 1'b1;
    bus(1'b1, `FREQ_OFFSET, 32'h3e7, rd);
    bus(1'b1, `CTRL_OFFSET, 32'h4, rd);
    repeat (200) @(posedge core_clk);
    checkVal("lowFreq", 32'h0, 32'({delayTaps, loopLocked}));
    bus(1'b0, `STATUS_OFFSET, '0, rd);
    checkVal("lowStat", 32'h80, rd & 32'h780);
    bus(1'b1, `FREQ_OFFSET, 32'h3e8, rd);
    bus(1'b0, `STATUS_OFFSET, '0, rd);
    checkVal("minStat", 32'h400, rd & 32'h400);
    $display("test frequency range done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, `CTRL_OFFSET, '0, rd);
    checkVal("ctrlAgain", 32'h5, rd);
    $display("test reset done");
    stopTest();
  end
endmodule
